// ### shared/sagp_map.svh
`ifndef SAGP_MAP_SVH
`define SAGP_MAP_SVH
// register byte offsets
`define SAGP_OFF_LEVELS 12'h000
`define SAGP_OFF_LATCH  12'h004
`define SAGP_OFF_DIR    12'h008
`define SAGP_OFF_CONV   12'h00c
`define SAGP_OFF_CMP    12'h010
`define SAGP_OFF_REF    12'h014
// reset values
`define SAGP_RST_LATCH  8'h00
`define SAGP_RST_DIR    8'hff
`define SAGP_RST_CONV   6'h00
`define SAGP_RST_CMP    6'h00
`define SAGP_RST_REF    8'h00
`define SAGP_RST_ANALOG 8'h7f
`define SAGP_RST_SSN    1'h1
// pin masks and pin positions
`define SAGP_ALL_PINS   8'hff
`define SAGP_NO_PIN0    8'hfe
`define SAGP_CMPIN_MASK 8'h78
`define SAGP_PIN_SECOND_COMPARATOR_RESULT  3'h1
`define SAGP_PIN_FIRST_COMPARATOR_RESULT  3'h2
`define SAGP_PIN_REF    3'h5
`define SAGP_PIN_SS     3'h7
// field positions and codes
`define SAGP_REF_OE_BIT 6
`define SAGP_CMP_OFF    3'h7
`define SAGP_CMP_OUTMODE 3'h3
`define SAGP_CHAN_BASE  5'h05
`define SAGP_CHAN_LIMIT 5'h10
`endif

// ### shared/sagp_pkg.sv
package sagp_pkg;
	typedef logic [11:0] sagp_addr_t;
	typedef logic [7:0]  sagp_byte_t;

	typedef struct packed {
		logic [31:0] rdata;
		logic        err;
	} sagp_apb_t;

	typedef struct packed {
		sagp_byte_t  sample;
		sagp_byte_t  latch;
		sagp_byte_t  dir;
		logic [5:0]  conv;
		logic [5:0]  cmp;
		sagp_byte_t  refCtl;
		sagp_byte_t  pinOut;
		sagp_byte_t  pinOe;
		sagp_byte_t  analogSel;
		sagp_byte_t  digIn;
		logic        ssN;
	} sagp_state_t;
endpackage

// ### shared/sagp_reg_if.sv
`timescale 1ns/1ns
interface sagp_reg_if;
	logic                wrEn;
	sagp_pkg::sagp_addr_t addr;
	sagp_pkg::sagp_byte_t wdata;
	sagp_pkg::sagp_byte_t rdata;
	logic                hit;

	modport bridge(output wrEn, addr, wdata, input rdata, hit);
	modport regs(input wrEn, addr, wdata, output rdata, hit);
endinterface

// ### src/sagp_apb_slave.sv
`timescale 1ns/1ns
module sagp_apb_slave (
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rstn,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire sagp_pkg::sagp_addr_t paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic                      pready,
	output logic [31:0]               prdata,
	output logic                      pslverr,
	// register side
	sagp_reg_if.bridge                regs
);
	sagp_pkg::sagp_apb_t st;
	sagp_pkg::sagp_apb_t next_st;

	// zero wait states: read data is caught in the setup cycle
	assign pready     = 1'b1;
	assign prdata     = st.rdata;
	assign pslverr    = st.err;
	assign regs.addr  = paddr;
	assign regs.wdata = pwdata[7:0];
	// data sits in lane 0 only, so lane 0 strobe gates writes
	assign regs.wrEn  = psel & penable & pwrite & regs.hit & pstrb[0];

	always_comb
	begin
		next_st = st;
		if (psel && !penable)
		begin
			next_st.rdata = pwrite ? 32'h0 : {24'h0, regs.rdata};
			next_st.err   = !regs.hit;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			st <= '{rdata: 32'h0, err: 1'h0};
		else
			st <= next_st;
	end
endmodule

// ### src/sagp_pin_mux.sv
`timescale 1ns/1ns
`include "sagp_map.svh"
module sagp_pin_mux #(
	parameter logic [7:0] PRESENT = `SAGP_ALL_PINS
) (
	// register view
	input  wire sagp_pkg::sagp_byte_t latch,
	input  wire sagp_pkg::sagp_byte_t dir,
	input  wire logic [3:0]           pinSelect,
	input  wire logic [2:0]           cmpMode,
	input  wire logic                 refOe,
	// comparator results
	input  wire logic                 firstResult,
	input  wire logic                 secondResult,
	// pin steering
	output sagp_pkg::sagp_byte_t      drvOut,
	output sagp_pkg::sagp_byte_t      drvOe,
	output sagp_pkg::sagp_byte_t      analogSel,
	output sagp_pkg::sagp_byte_t      digEn
);
	// a higher select value pushes more channels to digital
	function automatic logic is_analog(input logic [3:0] sel, input logic [2:0] pin);
		logic [4:0] sum;
		sum = {1'b0, sel} + `SAGP_CHAN_BASE + {2'b00, pin};
		return sum < `SAGP_CHAN_LIMIT;
	endfunction

	// a literal cannot be indexed, so the mask gets a name
	localparam logic [7:0] CMPIN = `SAGP_CMPIN_MASK;

	logic cmpOutEn;
	logic refBlock;

	always_comb
	begin
		cmpOutEn = (cmpMode == `SAGP_CMP_OUTMODE);
		refBlock = 1'b0;
		drvOut   = latch;
		drvOe    = 8'h00;
		analogSel = 8'h00;
		digEn    = 8'h00;
		for (int k = 0; k < 8; k++)
		begin
			// channel five base
			// a running comparator owns its input pins
			analogSel[k] = PRESENT[k] && (3'(k) != `SAGP_PIN_SS)
				&& (is_analog(pinSelect, 3'(k))
				|| (CMPIN[k] && cmpMode != `SAGP_CMP_OFF));
			refBlock = (3'(k) == `SAGP_PIN_REF) && refOe;
			digEn[k] = PRESENT[k] && !analogSel[k] && !refBlock;
			drvOe[k] = PRESENT[k] && !dir[k] && !refBlock;
		end
		if (cmpOutEn)
		begin
			drvOut[`SAGP_PIN_SECOND_COMPARATOR_RESULT] = secondResult;
			drvOut[`SAGP_PIN_FIRST_COMPARATOR_RESULT] = firstResult;
		end
	end
endmodule

// ### src/sagp_port.sv
// Behaviour
// - A pin whose direction bit is 0 is driven from its latch bit, analog select or not.
// - A pin whose direction bit is 1 reads through the data register unless it is analog.
// - Out of reset the analog pins are converter inputs, channel 5 on pin 0 upward.
// - With comparator output on, pin 1 shows comparator 2 and pin 2 comparator 1.
// - With the reference output on, pin 5 neither drives nor reads digitally.
// - A comparator-input pin selected as analog still drives while its direction is 0.
// - Pin 7 feeds the serial slave select while an input and is plain digital otherwise.
// - Pin 0 and its bits exist only in the largest variant.
// - Unimplemented register bits read as zero.
// - Direction 1 floats the driver and direction 0 puts the latch on the pin.
// - After any reset pins 6 to 1 are analog and read as zero.
// - Reading the latch register returns the latch, not the pin.
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ns
`include "sagp_map.svh"
module sagp_port #(
	parameter logic HAS_PIN0 = 1'b1
) (
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rstn,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire sagp_pkg::sagp_addr_t paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic                      pready,
	output logic [31:0]               prdata,
	output logic                      pslverr,
	// port pins
	input  wire sagp_pkg::sagp_byte_t pinIn,
	output sagp_pkg::sagp_byte_t      pinOut,
	output sagp_pkg::sagp_byte_t      pinOe,
	// analog and serial neighbours
	input  wire logic                 firstComparatorResult,
	input  wire logic                 secondComparatorResult,
	output sagp_pkg::sagp_byte_t      analogSelect,
	output logic [1:0]                converterRefSelect,
	output logic [5:0]                comparatorSetting,
	output sagp_pkg::sagp_byte_t      referenceSetting,
	output logic                      referenceOutputEnable,
	output logic                      serialSlaveSelectN
);
	localparam logic [7:0] PRESENT = HAS_PIN0 ? `SAGP_ALL_PINS : `SAGP_NO_PIN0;

	sagp_pkg::sagp_state_t st;
	sagp_pkg::sagp_state_t next_st;
	sagp_pkg::sagp_byte_t  drvOut;
	sagp_pkg::sagp_byte_t  drvOe;
	sagp_pkg::sagp_byte_t  anaSel;
	sagp_pkg::sagp_byte_t  digEn;

	sagp_reg_if regBus ();

	function automatic logic reg_hit(input sagp_pkg::sagp_addr_t a);
		return a == `SAGP_OFF_LEVELS || a == `SAGP_OFF_LATCH
			|| a == `SAGP_OFF_DIR || a == `SAGP_OFF_CONV
			|| a == `SAGP_OFF_CMP || a == `SAGP_OFF_REF;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	sagp_apb_slave u_apb (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pstrb   (pstrb),
		.pready  (pready),
		.prdata  (prdata),
		.pslverr (pslverr),
		.regs    (regBus.bridge)
	);

	sagp_pin_mux #(
		.PRESENT (PRESENT)
	) u_mux (
		.latch        (st.latch),
		.dir          (st.dir),
		.pinSelect    (st.conv[3:0]),
		.cmpMode      (st.cmp[2:0]),
		.refOe        (st.refCtl[`SAGP_REF_OE_BIT]),
		.firstResult  (firstComparatorResult),
		.secondResult (secondComparatorResult),
		.drvOut       (drvOut),
		.drvOe        (drvOe),
		.analogSel    (anaSel),
		.digEn        (digEn)
	);

	////////////////////////////////////////////////////////////////////////////////
	assign regBus.hit = reg_hit(regBus.addr);

	always_comb
	begin
		regBus.rdata = 8'h00;
		unique case (regBus.addr)
			`SAGP_OFF_LEVELS: regBus.rdata = st.digIn & PRESENT;
			`SAGP_OFF_LATCH:  regBus.rdata = st.latch & PRESENT;
			`SAGP_OFF_DIR:    regBus.rdata = st.dir & PRESENT;
			`SAGP_OFF_CONV:   regBus.rdata = {2'h0, st.conv};
			`SAGP_OFF_CMP:    regBus.rdata = {secondComparatorResult,
				firstComparatorResult, st.cmp};
			`SAGP_OFF_REF:    regBus.rdata = st.refCtl;
			default:          regBus.rdata = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_st        = st;
		next_st.sample = pinIn;
		next_st.digIn  = st.sample & digEn;
		next_st.pinOut = drvOut & PRESENT;
		next_st.pinOe  = drvOe;
		next_st.analogSel = anaSel;
		next_st.ssN    = st.dir[`SAGP_PIN_SS] ? st.sample[`SAGP_PIN_SS] : 1'b1;
		if (regBus.wrEn)
		begin
			// writes to the data register land in the latch
			unique case (regBus.addr)
				`SAGP_OFF_LEVELS: next_st.latch = regBus.wdata;
				`SAGP_OFF_LATCH:  next_st.latch = regBus.wdata;
				`SAGP_OFF_DIR:    next_st.dir = regBus.wdata;
				`SAGP_OFF_CONV:   next_st.conv = regBus.wdata[5:0];
				`SAGP_OFF_CMP:    next_st.cmp = regBus.wdata[5:0];
				`SAGP_OFF_REF:    next_st.refCtl = regBus.wdata;
				default:          next_st = next_st;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			st <= '{sample: 8'h00, latch: `SAGP_RST_LATCH, dir: `SAGP_RST_DIR,
				conv: `SAGP_RST_CONV, cmp: `SAGP_RST_CMP, refCtl: `SAGP_RST_REF,
				pinOut: 8'h00, pinOe: 8'h00, analogSel: `SAGP_RST_ANALOG,
				digIn: 8'h00, ssN: `SAGP_RST_SSN};
		else
			st <= next_st;
	end

	////////////////////////////////////////////////////////////////////////////////
	assign pinOut                = st.pinOut;
	assign pinOe                 = st.pinOe;
	// pin 0 analog bit is held low when the pin is absent
	assign analogSelect          = st.analogSel & PRESENT;
	assign converterRefSelect    = st.conv[5:4];
	assign comparatorSetting     = st.cmp;
	assign referenceSetting      = st.refCtl;
	assign referenceOutputEnable = st.refCtl[`SAGP_REF_OE_BIT];
	assign serialSlaveSelectN    = st.ssN;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	sequence s_readSetup(sagp_pkg::sagp_addr_t a);
		psel && !penable && !pwrite && paddr == a;
	endsequence

	sequence s_readAccess(sagp_pkg::sagp_addr_t a);
		s_readSetup(a) ##1 (psel && penable);
	endsequence

	property p_latchDrive;
		!st.dir[3] ##1 !st.dir[3] |=> pinOe[3] && pinOut[3] == $past(st.latch[3]);
	endproperty
	a_latchDrive: assert property (p_latchDrive)
		else $error("output pin does not follow its latch");

	property p_analogBlocksInput;
		anaSel[4] |=> st.digIn[4] == 1'b0;
	endproperty
	a_analogBlocksInput: assert property (p_analogBlocksInput)
		else $error("analog pin reads as digital");

	property p_digitalInput;
		digEn[6] && st.sample[6] |=> st.digIn[6];
	endproperty
	a_digitalInput: assert property (p_digitalInput)
		else $error("enabled input not reflected in data");

	property p_resetAnalog;
		$rose(rstn) |-> (analogSelect[6:1] == 6'h3f && st.digIn[6:1] == 6'h00)[*2];
	endproperty
	a_resetAnalog: assert property (p_resetAnalog)
		else $error("pins not analog after reset");

	property p_channelFiveDefault;
		$rose(rstn) |-> analogSelect[0] == HAS_PIN0;
	endproperty
	a_channelFiveDefault: assert property (p_channelFiveDefault)
		else $error("pin 0 not converter input after reset");

	property p_cmpOutput;
		st.cmp[2:0] == `SAGP_CMP_OUTMODE && !st.dir[1]
			|=> pinOe[1] && pinOut[1] == $past(secondComparatorResult);
	endproperty
	a_cmpOutput: assert property (p_cmpOutput)
		else $error("comparator 2 output missing on pin 1");

	property p_cmpOutputOne;
		st.cmp[2:0] == `SAGP_CMP_OUTMODE |=> pinOut[2] == $past(firstComparatorResult);
	endproperty
	a_cmpOutputOne: assert property (p_cmpOutputOne)
		else $error("comparator 1 output missing on pin 2");

	property p_refBlocksPin;
		referenceOutputEnable |=> !pinOe[5] && !st.digIn[5];
	endproperty
	a_refBlocksPin: assert property (p_refBlocksPin)
		else $error("pin 5 digital while reference output on");

	property p_analogStillDrives;
		anaSel[6] && !st.dir[6] && !st.refCtl[`SAGP_REF_OE_BIT] |=> pinOe[6];
	endproperty
	a_analogStillDrives: assert property (p_analogStillDrives)
		else $error("analog select stopped the driver");

	property p_slaveSelect;
		st.dir[7] |=> serialSlaveSelectN == $past(st.sample[7]);
	endproperty
	a_slaveSelect: assert property (p_slaveSelect)
		else $error("slave select does not follow pin 7");

	property p_slaveIdle;
		!st.dir[7] |=> serialSlaveSelectN && !analogSelect[7];
	endproperty
	a_slaveIdle: assert property (p_slaveIdle)
		else $error("pin 7 not plain digital as output");

	property p_pinZeroAbsent;
		!HAS_PIN0 |-> !pinOe[0] && !pinOut[0] && !analogSelect[0];
	endproperty
	a_pinZeroAbsent: assert property (p_pinZeroAbsent)
		else $error("absent pin 0 is active");

	property p_convTopZero;
		s_readAccess(`SAGP_OFF_CONV) |-> prdata[31:6] == 26'h0;
	endproperty
	a_convTopZero: assert property (p_convTopZero)
		else $error("unimplemented bits read nonzero");

	property p_dirFloats;
		st.dir[2] |=> !pinOe[2];
	endproperty
	a_dirFloats: assert property (p_dirFloats)
		else $error("input pin is driven");

	property p_latchRead;
		s_readAccess(`SAGP_OFF_LATCH) |-> prdata[7:0] == ($past(st.latch) & PRESENT);
	endproperty
	a_latchRead: assert property (p_latchRead)
		else $error("latch read returns wrong value");

	sequence s_write(sagp_pkg::sagp_addr_t a);
		psel && penable && pwrite && pstrb[0] && paddr == a;
	endsequence

	property p_writeLatch;
		s_write(`SAGP_OFF_LATCH) |=> st.latch == $past(pwdata[7:0]);
	endproperty
	a_writeLatch: assert property (p_writeLatch)
		else $error("latch write lost");

	property p_levelsWriteLatch;
		s_write(`SAGP_OFF_LEVELS) |=> st.latch == $past(pwdata[7:0]);
	endproperty
	a_levelsWriteLatch: assert property (p_levelsWriteLatch)
		else $error("data register write missed the latch");

	property p_dirWrite;
		s_write(`SAGP_OFF_DIR) |=> st.dir == $past(pwdata[7:0]);
	endproperty
	a_dirWrite: assert property (p_dirWrite)
		else $error("direction write lost");

	property p_convWrite;
		s_write(`SAGP_OFF_CONV) |=> st.conv == $past(pwdata[5:0]);
	endproperty
	a_convWrite: assert property (p_convWrite)
		else $error("converter config write wrong");

	property p_unmappedError;
		psel && !penable && !reg_hit(paddr) |=> pslverr && prdata == 32'h0;
	endproperty
	a_unmappedError: assert property (p_unmappedError)
		else $error("unmapped access not refused");

	property p_latchDriveAll;
		st.cmp[2:0] != `SAGP_CMP_OUTMODE |=> pinOut == ($past(st.latch) & PRESENT);
	endproperty
	a_latchDriveAll: assert property (p_latchDriveAll)
		else $error("pin values differ from latch");

	property p_oeFollowsDir;
		!st.refCtl[`SAGP_REF_OE_BIT] |=> pinOe == (~$past(st.dir) & PRESENT);
	endproperty
	a_oeFollowsDir: assert property (p_oeFollowsDir)
		else $error("driver enables differ from direction");

	property p_levelsRead;
		s_readAccess(`SAGP_OFF_LEVELS) |-> prdata[7:0] == ($past(st.digIn) & PRESENT);
	endproperty
	a_levelsRead: assert property (p_levelsRead)
		else $error("data register read wrong");

	property p_convAllDigital;
		st.conv[3:0] == 4'hf && st.cmp[2:0] == `SAGP_CMP_OFF |=> analogSelect == 8'h00;
	endproperty
	a_convAllDigital: assert property (p_convAllDigital)
		else $error("pins still analog in digital setting");

	property p_convAllAnalog;
		st.conv[3:0] == 4'h0 |=> analogSelect[6:1] == 6'h3f;
	endproperty
	a_convAllAnalog: assert property (p_convAllAnalog)
		else $error("pins not analog in default setting");
endmodule

// ### dv/sagp_pin_board.sv
`timescale 1ns/1ns
module sagp_pin_board (
	// device side
	input  wire sagp_pkg::sagp_byte_t pinOut,
	input  wire sagp_pkg::sagp_byte_t pinOe,
	// board side
	input  wire sagp_pkg::sagp_byte_t extLevel,
	output sagp_pkg::sagp_byte_t      pinIn
);
	// board drives every pin the device leaves floating
	assign pinIn = (pinOut & pinOe) | (extLevel & ~pinOe);
endmodule

// ### dv/shared_analog_gpio_port_tb_top.sv
`timescale 1ns/1ns
`include "sagp_map.svh"
module shared_analog_gpio_port_tb_top;
	logic                 clk_sys, rstn, psel, penable, pwrite, first, second;
	sagp_pkg::sagp_addr_t paddr;
	logic [31:0]          pwdata, prdata, prdata2, rd, rd2;
	logic                 pready, pslverr, ssN, refOe, err;
	logic [1:0]           refSel;
	logic [5:0]           cmpSet;
	sagp_pkg::sagp_byte_t refSet;
	sagp_pkg::sagp_byte_t pinIn, pinOut, pinOe, anaSel, ext, pinIn2, pinOut2, pinOe2, anaSel2;
	int                   mismatches, checked;
	sagp_port dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
		.firstComparatorResult(first), .secondComparatorResult(second),
		.analogSelect(anaSel), .converterRefSelect(refSel), .comparatorSetting(cmpSet),
		.referenceSetting(refSet), .referenceOutputEnable(refOe), .serialSlaveSelectN(ssN));
	// smaller variant shares the bus
	sagp_port #(.HAS_PIN0(1'b0)) dut2 (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
		.pready(), .prdata(prdata2), .pslverr(), .pinIn(pinIn2), .pinOut(pinOut2),
		.pinOe(pinOe2), .firstComparatorResult(first), .secondComparatorResult(second),
		.analogSelect(anaSel2), .converterRefSelect(), .comparatorSetting(),
		.referenceSetting(), .referenceOutputEnable(), .serialSlaveSelectN());
	sagp_pin_board board (.pinOut(pinOut), .pinOe(pinOe), .extLevel(ext), .pinIn(pinIn));
	sagp_pin_board board2 (.pinOut(pinOut2), .pinOe(pinOe2), .extLevel(ext), .pinIn(pinIn2));
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		if (mismatches == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// request held until pready seen high at an edge
	task automatic apb(input logic w, input sagp_pkg::sagp_addr_t a, input logic [7:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1)
			@(posedge clk_sys);
		rd = prdata;
		rd2 = prdata2;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// pins follow registers a couple of edges later
	task automatic settle();
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		ext <= 8'hff;
		settle();
		chk(anaSel, 8'h7f); // analog default
		chk(anaSel2, 8'h7e); // no pin zero
		chk(pinOe, 8'h00); // inputs float
		apb(1'b0, `SAGP_OFF_LEVELS, 8'h0);
		chk(rd, 32'h80); // analog reads zero
		apb(1'b0, `SAGP_OFF_DIR, 8'h0);
		chk(rd, 32'hff);
		chk(rd2, 32'hfe); // bit zero absent
		apb(1'b0, `SAGP_OFF_LATCH, 8'h0);
		chk(rd, 32'h0);
		apb(1'b0, `SAGP_OFF_CONV, 8'h0);
		chk(rd, 32'h0);
		apb(1'b0, `SAGP_OFF_REF, 8'h0);
		chk(rd, 32'h0);
	endtask
	task automatic t_digital();
		apb(1'b1, `SAGP_OFF_CMP, 8'h07);
		apb(1'b1, `SAGP_OFF_CONV, 8'hff);
		apb(1'b0, `SAGP_OFF_CONV, 8'h0);
		chk(rd, 32'h3f); // upper bits zero
		ext <= 8'ha5;
		settle();
		chk(anaSel, 8'h00); // digital mode
		chk(refSel, 2'h3);
		chk(cmpSet, 6'h07);
		apb(1'b0, `SAGP_OFF_LEVELS, 8'h0);
		chk(rd, 32'ha5); // digital read
		chk(rd2, 32'ha4); // missing pin zero
		apb(1'b0, 12'h018, 8'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0); // unmapped reads zero
	endtask
	task automatic t_output();
		apb(1'b1, `SAGP_OFF_LATCH, 8'h5a);
		apb(1'b1, `SAGP_OFF_DIR, 8'h00);
		ext <= 8'ha5;
		settle();
		chk(pinOe, 8'hff); // drivers on
		chk(pinOut & pinOe, 8'h5a); // latch on pins
		chk(pinOe2, 8'hfe); // pin zero never driven
		apb(1'b0, `SAGP_OFF_LATCH, 8'h0);
		chk(rd, 32'h5a); // latch not pin
		apb(1'b1, `SAGP_OFF_CONV, 8'h00);
		settle();
		chk(anaSel, 8'h7f);
		chk(pinOut & pinOe, 8'h5a); // analog keeps driver
	endtask
	task automatic t_compare();
		first <= 1'b1;
		second <= 1'b0;
		apb(1'b1, `SAGP_OFF_CMP, 8'h03);
		settle();
		chk(pinOut & pinOe, 8'h5c); // results override latch
		apb(1'b0, `SAGP_OFF_CMP, 8'h0);
		chk(rd, 32'h43);
		second <= 1'b1;
		settle();
		chk(pinOut & pinOe, 8'h5e); // second result on pin one
		apb(1'b1, `SAGP_OFF_CMP, 8'h07);
		apb(1'b1, `SAGP_OFF_CONV, 8'h0f);
	endtask
	task automatic t_reference();
		apb(1'b1, `SAGP_OFF_REF, 8'h40);
		settle();
		chk(refOe, 1'b1);
		chk(refSet, 8'h40);
		chk(pinOe, 8'hdf); // pin five not driven
		apb(1'b1, `SAGP_OFF_DIR, 8'hff);
		ext <= 8'hff;
		settle();
		apb(1'b0, `SAGP_OFF_LEVELS, 8'h0);
		chk(rd, 32'hdf); // pin five not read
		apb(1'b1, `SAGP_OFF_REF, 8'h00);
	endtask
	task automatic t_select();
		ext <= 8'h7f;
		settle();
		chk(ssN, 1'b0); // input feeds select
		apb(1'b1, `SAGP_OFF_DIR, 8'h7f);
		settle();
		chk(ssN, 1'b1); // output releases select
		chk(pinOe, 8'h80);
		apb(1'b1, 12'h002, 8'h11);
		chk(err, 1'b1);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		first = 1'b0;
		second = 1'b0;
		ext = 8'hff;
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		t_reset();
		t_digital();
		t_output();
		t_compare();
		t_reference();
		t_select();
		end_of_test();
	end
	// whole run is well under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		mismatches++;
		end_of_test();
	end
endmodule
